// File: egress_header_formatter.sv
// egress header formatter: header modes, injected-frame flags, per-port disassembler setup
// Function
// [R1] per-port header mode: 0 normal, 1 keep internal header untouched
// [R2] mode 2 emits addresses, type, protocol id 0x0009, header, frame
// [R3] mode 3 emits table entry picked by lookup id, header, frame
// [R4] insertion enabled on a port applies to every frame of that port
// [R5] frames to CPU ports always use mode 1
// [R6] external receiver of mode-1 frames must parse leading header
// [R7] modes 2 and 3 include inserted header in checksum
// [R8] CPU injects frames with leading header in mode-1 layout
// [R9] bypass flag forwards frame unchanged except checksum refresh
// [R10] refresh flag forces checksum recomputation
// [R11] exchange flag swaps addresses, clears bit 40 of new source
// [R12] exchange forces checksum update; never combined with bypass
// [R13] per-port bit stops statistics collection
// [R14] per-port watermark caps port transmit buffer fill
// [R15] low-speed ports use watermark 1 at 100 or 10 Mbps
// [R16] per-port shadow bit lets fast ports run slower
// [R17] ports 0 to 10 front, 11 to 12 CPU
// [R18] cell buffer aligns rewriter data into words for port modules
// [R19] per-port flush empties only that port's buffer
// [R20] controller stops forwarding and flow control before flushing
// [R21] flush discards held cells, realigns to frame, self-clears
// [R22] header mode change applies from next frame start
module egress_header_formatter
   import egress_header_formatter_pkg::*;
#(
   parameter logic [15:0] TAG_TYPE = 16'hA5A5  // arbitrary value
) (
   input  wire logic             clk,
   input  wire logic             sys_rst,
   input  wire logic [7:0]       reg_addr,
   input  wire logic [31:0]      reg_wdata,
   input  wire logic             reg_wr,
   input  wire logic             reg_rd,
   output logic [31:0]           reg_rdata,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire in_type           in_word,
   input  wire logic [WM_W-1:0]  tx_level,
   input  wire logic             out_ready,
   output out_type               out_word,
   output logic                  stat_frame,
   output logic [3:0]            stat_port,
   output logic [PORTS-1:0]      stats_disable,
   output logic [PORTS-1:0]      shadow_enable
);

   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      fsm_type                            fsm;
      logic [3:0]                         port;
      mode_type                           mode;
      logic                               bypass;
      logic                               refresh;
      logic                               exchange;
      logic [1:0]                         eid;
      logic [4:0]                         cnt;
      logic [5:0]                         idx;
      logic                               cap_eof;
      logic [STORE_BYTES-1:0][7:0]        store;
      cfg_type [PORTS-1:0]                cfg;
      logic [ENC_ENTRIES*ENC_BYTES-1:0][7:0] enc;
      out_type                            o;
      logic [31:0]                        rdata;
      logic                               stat_frame;
      logic [3:0]                         stat_port;
   } state_type;

   state_type s_reg;
   state_type s_next;

   // ************************************************************
   // helpers
   // ************************************************************
   function automatic int pre_len(mode_type m);
      int r;
      r = 0;
      if (m == MODE_PREPEND_TABLE_ENTRY_TAG) begin
         r = ADDR_BYTES + TAG_BYTES;
      end else if (m == MODE_PREPEND_TABLE_ENTRY_TABLE) begin
         r = ENC_BYTES;
      end
      return r;
   endfunction

   function automatic int hdr_len(mode_type m);
      return (m == MODE_NORMAL) ? 0 : IFH_BYTES;
   endfunction

   // [R11] address exchange
   function automatic logic [7:0] addr_byte(state_type s, int k);
      logic [7:0] b;
      b = s.store[IFH_BYTES + k];
      if (s.exchange && !s.bypass) begin
         if (k < MAC_BYTES) begin
            b = s.store[IFH_BYTES + MAC_BYTES + k];
         end else begin
            b = s.store[IFH_BYTES + k - MAC_BYTES];
            if (k == MAC_BYTES) begin
               b = b & MCAST_CLR_MASK;
            end
         end
      end
      return b;
   endfunction

   function automatic logic [7:0] prefix_byte(state_type s);
      int         i;
      int         p;
      logic [7:0] b;
      logic [31:0] tag;
      i   = int'(s.idx);
      p   = pre_len(s.mode);
      tag = {TAG_TYPE, PROTO_ID};
      b   = 8'h00;
      if (i < p) begin
         // [R2] tag encapsulation
         if (s.mode == MODE_PREPEND_TABLE_ENTRY_TAG) begin
            if (i < ADDR_BYTES) begin
               b = addr_byte(s, i);
            end else begin
               b = tag[8*(ADDR_BYTES + TAG_BYTES - 1 - i) +: 8];
            end
         // [R3] table entry
         end else begin
            b = s.enc[int'(s.eid) * ENC_BYTES + i];
         end
      end else if (i - p < hdr_len(s.mode)) begin
         b = s.store[i - p];
      end else begin
         b = addr_byte(s, i - p - hdr_len(s.mode));
      end
      return b;
   endfunction

   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      logic             can_load;
      logic             cap_ok;
      logic             ld;
      logic             ld_sof;
      logic             ld_eof;
      logic [7:0]       ld_data;
      logic [5:0]       last;
      logic [PORTS-1:0] flush;
      int               pi;
      can_load = !s_reg.o.valid || out_ready;
      // [R14] [R15] fill cap towards the port module
      cap_ok   = (s_reg.port < 4'(PORTS)) && (tx_level < s_reg.cfg[s_reg.port].wm);
      ld       = 1'b0;
      ld_sof   = 1'b0;
      ld_eof   = 1'b0;
      ld_data  = 8'h00;
      last     = 6'(pre_len(s_reg.mode) + hdr_len(s_reg.mode) + ADDR_BYTES - 1);
      flush    = '0;
      pi       = int'(reg_addr[7:2]);
      in_ready = 1'b0;
      s_next   = s_reg;
      s_next.stat_frame = 1'b0;
      if (s_reg.o.valid && out_ready) begin
         s_next.o.valid = 1'b0;
      end

      case (s_reg.fsm)
         ST_IDLE: begin
            in_ready = 1'b1;
            if (in_valid && in_word.sof) begin
               s_next.port     = in_word.port;
               s_next.store[0] = in_word.data;
               s_next.cnt      = 5'd1;
               if (in_word.port >= 4'(PORTS) || in_word.eof) begin
                  s_next.fsm = in_word.eof ? ST_IDLE : ST_DRAIN;
               end else begin
                  s_next.fsm = ST_CAPTURE;
                  // [R4] [R22] every frame takes the mode latched at start
                  s_next.mode = s_reg.cfg[in_word.port].mode;
                  // [R5] CPU ports forced to keep header
                  if (in_word.port >= 4'(CPU_FIRST)) begin
                     s_next.mode = MODE_KEEP;
                  end
               end
            end
         end
         // [R18] align header and addresses before emitting
         ST_CAPTURE: begin
            in_ready = 1'b1;
            if (in_valid) begin
               s_next.store[s_reg.cnt] = in_word.data;
               s_next.cnt = s_reg.cnt + 5'd1;
               if (s_reg.cnt == 5'(STORE_BYTES - 1)) begin
                  // [R8] flags read from injected header
                  s_next.bypass   = s_reg.store[0][HDR_BYPASS_BIT];
                  s_next.refresh  = s_reg.store[0][HDR_REFRESH_BIT];
                  s_next.exchange = s_reg.store[0][HDR_EXCHANGE_BIT];
                  s_next.eid      = s_reg.store[HDR_PREPEND_TABLE_ENTRY_BYTE][1:0];
                  s_next.cap_eof  = in_word.eof;
                  s_next.idx      = '0;
                  s_next.fsm      = ST_PREFIX;
               end else if (in_word.eof) begin
                  // runt: too short to carry header and addresses
                  s_next.fsm = ST_IDLE;
               end
            end
         end
         // [R1] emit the chosen front part
         ST_PREFIX: begin
            if (can_load && cap_ok) begin
               ld      = 1'b1;
               ld_sof  = (s_reg.idx == 6'd0);
               ld_data = prefix_byte(s_reg);
               s_next.idx = s_reg.idx + 6'd1;
               if (s_reg.idx == last) begin
                  ld_eof     = s_reg.cap_eof;
                  s_next.fsm = s_reg.cap_eof ? ST_IDLE : ST_BODY;
               end
            end
         end
         // [R9] remainder passes unchanged
         ST_BODY: begin
            in_ready = can_load && cap_ok;
            if (in_valid && in_ready) begin
               ld      = 1'b1;
               ld_eof  = in_word.eof;
               ld_data = in_word.data;
               if (in_word.eof) begin
                  s_next.fsm = ST_IDLE;
               end
            end
         end
         ST_DRAIN: begin
            in_ready = 1'b1;
            if (in_valid && in_word.eof) begin
               s_next.fsm = ST_IDLE;
            end
         end
         default: begin
            s_next.fsm = ST_IDLE;
         end
      endcase

      if (ld) begin
         s_next.o.valid = 1'b1;
         s_next.o.sof   = ld_sof;
         s_next.o.eof   = ld_eof;
         s_next.o.port  = s_reg.port;
         s_next.o.data  = ld_data;
         // [R7] [R10] [R12] checksum refresh and coverage
         s_next.o.fcs_all    = (s_reg.mode == MODE_PREPEND_TABLE_ENTRY_TAG) || (s_reg.mode == MODE_PREPEND_TABLE_ENTRY_TABLE);
         s_next.o.update_fcs = s_next.o.fcs_all || s_reg.refresh || (s_reg.exchange && !s_reg.bypass);
         // [R13] statistics gate
         if (ld_eof && !s_reg.cfg[s_reg.port].stat_dis) begin
            s_next.stat_frame = 1'b1;
            s_next.stat_port  = s_reg.port;
         end
      end

      // ************************************************************
      // register port
      // ************************************************************
      s_next.rdata = 32'h0000_0000;
      if (reg_wr) begin
         // [R17] one config word for each of ports 0 to 12
         if (reg_addr < OFF_PREPEND_TABLE_ENTRY_WR && pi < PORTS) begin
            s_next.cfg[pi].mode     = mode_type'(reg_wdata[CFG_MODE_LSB +: 2]);
            s_next.cfg[pi].stat_dis = reg_wdata[CFG_STATDIS_BIT];
            s_next.cfg[pi].wm       = reg_wdata[CFG_WM_LSB +: WM_W];
            // [R16] low-speed shadow
            s_next.cfg[pi].shadow   = reg_wdata[CFG_SHADOW_BIT];
            flush[pi]               = reg_wdata[CFG_FLUSH_BIT];
         end else if (reg_addr == OFF_PREPEND_TABLE_ENTRY_WR) begin
            s_next.enc[{reg_wdata[ENCW_ENTRY_LSB +: 2], reg_wdata[ENCW_BYTE_LSB +: 3]}] =
               reg_wdata[7:0];
         end
      end
      if (reg_rd) begin
         if (reg_addr < OFF_PREPEND_TABLE_ENTRY_WR && pi < PORTS) begin
            s_next.rdata[CFG_MODE_LSB +: 2]    = s_reg.cfg[pi].mode;
            s_next.rdata[CFG_STATDIS_BIT]      = s_reg.cfg[pi].stat_dis;
            s_next.rdata[CFG_WM_LSB +: WM_W]   = s_reg.cfg[pi].wm;
            s_next.rdata[CFG_SHADOW_BIT]       = s_reg.cfg[pi].shadow;
         end else if (reg_addr == OFF_STATUS) begin
            s_next.rdata[2:0]                  = s_reg.fsm;
            s_next.rdata[STAT_PORT_LSB +: 4]   = s_reg.port;
            s_next.rdata[STAT_BUSY_BIT]        = s_reg.o.valid;
         end
      end

      // [R19] [R21] flush one port, drop to frame end, self-clearing
      for (int p = 0; p < PORTS; p++) begin
         if (flush[p]) begin
            if (s_next.o.valid && s_next.o.port == 4'(p)) begin
               s_next.o.valid = 1'b0;
            end
            if (s_next.stat_port == 4'(p)) begin
               s_next.stat_frame = 1'b0;
            end
            if (s_next.fsm != ST_IDLE && s_next.port == 4'(p)) begin
               s_next.fsm = (s_next.fsm == ST_PREFIX && s_next.cap_eof) ? ST_IDLE : ST_DRAIN;
            end
         end
      end
   end

   // ************************************************************
   // registers and outputs
   // ************************************************************
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_reg <= '0;
         for (int p = 0; p < PORTS; p++) begin
            s_reg.cfg[p].wm <= WM_RST;
         end
      end else begin
         s_reg <= s_next;
      end
   end

   always_comb begin
      for (int p = 0; p < PORTS; p++) begin
         stats_disable[p] = s_reg.cfg[p].stat_dis;
         shadow_enable[p] = s_reg.cfg[p].shadow;
      end
   end

   assign out_word   = s_reg.o;
   assign reg_rdata  = s_reg.rdata;
   assign stat_frame = s_reg.stat_frame;
   assign stat_port  = s_reg.stat_port;

endmodule

// File: egress_header_formatter_pkg.sv
// constants, types and register map of the egress header formatter
package egress_header_formatter_pkg;

   // ************************************************************
   // sizes
   // ************************************************************
   localparam int PORTS       = 13;
   localparam int FRONT_LAST  = 10;
   localparam int CPU_FIRST   = 11;
   localparam int IFH_BYTES   = 16;
   localparam int ADDR_BYTES  = 12;
   localparam int MAC_BYTES   = 6;
   localparam int TAG_BYTES   = 4;
   localparam int STORE_BYTES = IFH_BYTES + ADDR_BYTES;
   localparam int ENC_ENTRIES = 4;
   localparam int ENC_BYTES   = 8;
   localparam int WM_W        = 4;

   // ************************************************************
   // register map and fields
   // ************************************************************
   localparam logic [7:0]  OFF_PORT_CFG    = 8'h00;
   localparam logic [7:0]  OFF_PREPEND_TABLE_ENTRY_WR    = 8'h40;
   localparam logic [7:0]  OFF_STATUS      = 8'h44;
   localparam int          CFG_MODE_LSB    = 0;
   localparam int          CFG_STATDIS_BIT = 4;
   localparam int          CFG_WM_LSB      = 8;
   localparam int          CFG_SHADOW_BIT  = 12;
   localparam int          CFG_FLUSH_BIT   = 16;
   localparam int          ENCW_BYTE_LSB   = 8;
   localparam int          ENCW_ENTRY_LSB  = 16;
   localparam int          STAT_PORT_LSB   = 4;
   localparam int          STAT_BUSY_BIT   = 8;
   localparam logic [WM_W-1:0] WM_RST      = 4'hF;

   // ************************************************************
   // internal header flags and inserted tag
   // ************************************************************
   localparam int          HDR_BYPASS_BIT   = 0;
   localparam int          HDR_REFRESH_BIT  = 1;
   localparam int          HDR_EXCHANGE_BIT = 2;
   localparam int          HDR_PREPEND_TABLE_ENTRY_BYTE   = 1;
   localparam logic [15:0] PROTO_ID         = 16'h0009;
   localparam logic [7:0]  MCAST_CLR_MASK   = 8'hFE;

   typedef enum logic [1:0] {
      MODE_NORMAL, MODE_KEEP, MODE_PREPEND_TABLE_ENTRY_TAG, MODE_PREPEND_TABLE_ENTRY_TABLE
   } mode_type;

   typedef enum logic [2:0] {
      ST_IDLE    = 3'h0,
      ST_CAPTURE = 3'h1,
      ST_PREFIX  = 3'h3,
      ST_BODY    = 3'h2,
      ST_DRAIN   = 3'h6
   } fsm_type;

   typedef struct packed {
      mode_type        mode;
      logic            stat_dis;
      logic [WM_W-1:0] wm;
      logic            shadow;
   } cfg_type;

   typedef struct packed {
      logic       sof;
      logic       eof;
      logic [3:0] port;
      logic [7:0] data;
   } in_type;

   typedef struct packed {
      logic       valid;
      logic       sof;
      logic       eof;
      logic [3:0] port;
      logic [7:0] data;
      logic       update_fcs;
      logic       fcs_all;
   } out_type;

endpackage

// File: egress_header_formatter_checker.sv
// port assertions for the egress header formatter
// ************************************************************
// checker
// ************************************************************
module egress_header_formatter_checker
   import egress_header_formatter_pkg::*;
(
   input wire logic             clk,
   input wire logic             sys_rst,
   input wire logic [7:0]       reg_addr,
   input wire logic [31:0]      reg_wdata,
   input wire logic             reg_wr,
   input wire logic             reg_rd,
   input wire logic [31:0]      reg_rdata,
   input wire logic             in_valid,
   input wire logic             in_ready,
   input wire in_type           in_word,
   input wire logic [WM_W-1:0]  tx_level,
   input wire logic             out_ready,
   input wire out_type          out_word,
   input wire logic             stat_frame,
   input wire logic [3:0]       stat_port,
   input wire logic [PORTS-1:0] stats_disable,
   input wire logic [PORTS-1:0] shadow_enable
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data not zero outside answer");
   a_unmapped_zero: assert property (reg_rd && reg_addr inside {8'h34, 8'h38, 8'h3C, 8'h40} |=> reg_rdata == 32'h0)
      else $error("unmapped read not zero");
   a_flush_clear: assert property (reg_rd && reg_addr < 8'h34 |=> !reg_rdata[CFG_FLUSH_BIT])
      else $error("flush bit reads set");
   a_flush_drop: assert property (reg_wr && reg_addr < 8'h34 && reg_wdata[CFG_FLUSH_BIT] |=>
      !(out_word.valid && out_word.port == $past(reg_addr[5:2]))
      && !(stat_frame && stat_port == $past(reg_addr[5:2])))
      else $error("flushed port still has output");
   a_cfg_bits: assert property (reg_wr && reg_addr < 8'h34 && reg_addr[1:0] == 2'h0 |=>
      stats_disable[$past(reg_addr[7:2])] == $past(reg_wdata[CFG_STATDIS_BIT])
      && shadow_enable[$past(reg_addr[7:2])] == $past(reg_wdata[CFG_SHADOW_BIT]))
      else $error("port config bits not updated");
   a_stat_gate: assert property (stat_frame |-> stat_port <= 4'hC && !stats_disable[stat_port])
      else $error("stat pulse on disabled port");
   a_out_hold: assert property (out_word.valid && !out_ready && !reg_wr |=> $stable(out_word))
      else $error("output word changed while stalled");
   a_cpu_keep: assert property (out_word.valid && out_word.port >= 4'hB |-> !out_word.fcs_all)
      else $error("cpu port frame not in keep mode");
   a_fcs_insert: assert property (out_word.valid && out_word.fcs_all |-> out_word.update_fcs && out_word.port < 4'hB)
      else $error("inserted header without checksum update");
   c_insert: cover property (out_word.valid && out_word.fcs_all && out_ready);
   c_stat: cover property (stat_frame);
   c_stall: cover property ((out_word.valid && !out_ready) [*2]);
endmodule

bind egress_header_formatter egress_header_formatter_checker chk_u (.clk, .sys_rst, .reg_addr, .reg_wdata,
   .reg_wr, .reg_rd, .reg_rdata, .in_valid, .in_ready, .in_word, .tx_level, .out_ready, .out_word,
   .stat_frame, .stat_port, .stats_disable, .shadow_enable);

// File: port_module_model.sv
// port module model: takes output words with stalls, reports a buffer fill level
module port_module_model
   import egress_header_formatter_pkg::*;
(
   input  wire logic            clk,
   input  wire logic            sys_rst,
   input  wire logic            slow,
   output logic                 out_ready,
   output logic [WM_W-1:0]      tx_level
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] lfsr;
   always @(posedge clk) begin
      if (sys_rst) begin
         lfsr <= 8'h5A;
         out_ready <= 1'b0;
         tx_level <= '0;
      end else begin
         lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
         out_ready <= !slow || lfsr[0];
         tx_level <= slow ? lfsr[7:4] : 4'h0;
      end
   end
endmodule

// File: tb.sv
// self-checking bench for the egress header formatter
module tb
   import egress_header_formatter_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [15:0] TAG = 16'h3C5A;  // arbitrary value
   logic             clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, in_valid = 0, slow = 0, rd_d = 0;
   logic [7:0]       reg_addr = '0;
   logic [31:0]      reg_wdata = '0, reg_rdata;
   in_type           in_word = '0;
   logic             in_ready, out_ready, stat_frame;
   logic [WM_W-1:0]  tx_level;
   out_type          out_word;
   logic [3:0]       stat_port;
   logic [PORTS-1:0] stats_disable, shadow_enable, dis_cfg = '0;
   int               err_count = 0, samples_checked = 0, seed = 84357, stat_exp = 0, stat_seen = 0;
   logic [31:0]      rd_q[$];
   logic [15:0]      exp_q[$];
   logic [1:0]       mode_cfg[PORTS] = '{default: 2'h0};
   logic [7:0]       enc[ENC_ENTRIES][ENC_BYTES];

   always #12.5 clk = ~clk;
   egress_header_formatter #(.TAG_TYPE(TAG)) dut_u (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .in_valid, .in_ready, .in_word, .tx_level, .out_ready, .out_word,
      .stat_frame, .stat_port, .stats_disable, .shadow_enable);
   port_module_model pm_u (.clk, .sys_rst, .slow, .out_ready, .tx_level);

   // ************************************************************
   // checking
   // ************************************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      samples_checked++;
      if (seen !== want) begin
         err_count++;
         $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask
   task automatic conclude();
      if (err_count == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   always @(posedge clk) begin
      rd_d <= reg_rd;
      if (rd_d)
         check(reg_rdata, rd_q.pop_front());
      if (out_word.valid === 1'b1 && out_ready === 1'b1)
         check({16'h0, out_word[15:0]}, {16'h0, exp_q.pop_front()});
      if (stat_frame === 1'b1)
         stat_seen++;
   end

   // ************************************************************
   // drivers
   // ************************************************************
   // strobes drop, then one edge passes so the next access never reassigns in the same step
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] want);
      rd_q.push_back(want);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
   endtask
   // port setup, optional flush, read back for ports below CPU_FIRST
   task automatic cfg(input int p, input logic [1:0] md, input logic ds, input logic [3:0] wm, input logic fl);
      logic [31:0] v;
      v = {15'h0, fl, 3'h0, ds, wm, 3'h0, ds, 2'h0, md};
      wr(8'(4 * p), v);
      mode_cfg[p] = md;
      dis_cfg[p] = ds;
      if (p < CPU_FIRST)
         rd(8'(4 * p), v & 32'hFFFE_FFFF);
   endtask
   task automatic send(input int p, input logic [2:0] fl, input logic [1:0] id, input int len);
      logic [7:0] b[$], o[$], a[12];
      int m, k, n;
      // cpu ports always keep the header
      m = (p >= CPU_FIRST) ? 1 : mode_cfg[p];
      for (k = 0; k < len; k++)
         b.push_back(8'($random(seed)));
      // leading header carries the flags and entry id
      b[0] = {5'h0, fl};
      b[1] = {6'h0, id};
      for (k = 0; k < 12; k++)
         a[k] = b[16 + k];
      // exchange swaps, clears bit 40, never with bypass
      if (fl[2] && !fl[0]) begin
         for (k = 0; k < 12; k++)
            a[k] = b[16 + (k + 6) % 12];
         a[6] &= MCAST_CLR_MASK;
      end
      if (m == 3)
         for (k = 0; k < ENC_BYTES; k++)
            o.push_back(enc[id][k]);
      if (m == 2) begin
         for (k = 0; k < 12; k++)
            o.push_back(a[k]);
         o.push_back(TAG[15:8]);
         o.push_back(TAG[7:0]);
         o.push_back(PROTO_ID[15:8]);
         o.push_back(PROTO_ID[7:0]);
      end
      if (m != 0)
         for (k = 0; k < IFH_BYTES; k++)
            o.push_back(b[k]);
      for (k = 0; k < 12; k++)
         o.push_back(a[k]);
      for (k = STORE_BYTES; k < len; k++)
         o.push_back(b[k]);
      if (len >= STORE_BYTES) begin
         for (k = 0; k < o.size(); k++)
            exp_q.push_back({k == 0, k == o.size() - 1, 4'(p), o[k], m >= 2 || fl[1] || (fl[2] && !fl[0]), m >= 2});
         stat_exp += !dis_cfg[p];
      end
      for (k = 0; k < len; k++) begin
         in_valid <= 1'b1;
         in_word <= {k == 0, k == len - 1, 4'(p), b[k]};
         n = 0;
         @(negedge clk);
         while (in_ready !== 1'b1 && n < 3000) begin
            n++;
            @(negedge clk);
         end
         if (n == 3000) begin
            err_count++;
            conclude();
         end
         @(posedge clk);
      end
      in_valid <= 1'b0;
      @(posedge clk);
   endtask

   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      int n;
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      rd(OFF_PORT_CFG, 32'h0000_0F00);
      rd(8'h34, 32'h0);
      rd(OFF_PREPEND_TABLE_ENTRY_WR, 32'h0);
      rd(OFF_STATUS, 32'h0);
      for (int e = 0; e < ENC_BYTES; e++) begin
         enc[2][e] = 8'($random(seed));
         wr(OFF_PREPEND_TABLE_ENTRY_WR, {14'h0, 2'd2, 5'h0, 3'(e), enc[2][e]});
      end
      // flushes only while nothing is forwarded to the port
      cfg(0, 2'd0, 0, 4'hF, 1);
      cfg(1, 2'd1, 0, 4'h3, 1);
      cfg(2, 2'd2, 0, 4'h1, 1);
      cfg(3, 2'd3, 1, 4'h5, 1);
      cfg(11, 2'd2, 0, 4'hF, 0);
      send(0, 3'b000, 0, 32);
      send(0, 3'b100, 0, 33);
      send(1, 3'b010, 0, 30);
      send(2, 3'b011, 0, 31);
      send(3, 3'b000, 2, 29);
      send(11, 3'b000, 0, 28);
      send(10, 3'b001, 0, 32);
      send(4, 3'b000, 0, 20);
      // mode change mid-frame waits for next frame
      fork
         send(0, 3'b000, 0, 40);
         begin
            repeat (10) @(posedge clk);
            cfg(0, 2'd1, 0, 4'hF, 0);
            // flush of another port leaves this frame intact
            cfg(5, 2'd0, 0, 4'hF, 1);
         end
      join
      slow <= 1'b1;
      for (int i = 0; i < 12; i++)
         send($unsigned($random(seed)) % PORTS, 3'($random(seed) & 3), 2'd2, 28 + $unsigned($random(seed)) % 8);
      n = 0;
      while ((exp_q.size() > 0 || rd_q.size() > 0) && n < 5000) begin
         n++;
         @(posedge clk);
      end
      repeat (4) @(posedge clk);
      if (n == 5000)
         err_count++;
      check(stat_seen, stat_exp);
      conclude();
   end
endmodule
